// ---- core/lamp_pkg.sv ----
/*
 Constants, types and status carriers for the four-pin status lamp driver
 of a 10/100/1000 transceiver.
 Assumes the link status and the per-pin settings come from logic on
 ref_clk, and that ref_clk runs at 25 MHz.
*/
// Overview of operation
// - Four lamp outputs exist, each with its own four-bit mode field.
// - Lamps are active low from reset, and an invert setting flips that.
// - Mode 0 is off with no link, on with any link, and blinks on activity.
// - Modes 1 to 3 do the same but qualify only 1000, 100 or 10 Mb/s.
// - Modes 4 to 6 qualify 100 or 1000, 10 or 1000, and 10 or 100 Mb/s.
// - Mode 8 is on for full duplex and blinks on half-duplex collisions.
// - Mode 9 is off without collisions and blinks on a collision.
// - Mode 10 blinks on activity, or on transmit only when so selected.
// - Mode 12 is off with no negotiation fault and on while anegFault is set.
// - Mode 14 forces the lamp off and mode 15 forces it on.
// - A per-pin combine disable drops the activity or collision overlay, except in modes 9 and 10.
// - Blink toggles the lamp at 50% duty while the event condition holds.
// - Per-pin pulse stretch holds the lamp on, then off, for one period.
// - A per-pin rate picks a blink of 2.5, 5, 10 or 20 Hz.
// - The same rate picks a stretch of 50, 100, 200 or 400 ms.
package lamp_pkg;

  localparam int LAMP_COUNT = 4;

  // Clock and time base
  localparam int CLK_PERIOD_NS = 40;
  localparam int TICK_PERIOD_MS = 25;
  localparam int TICK_CYCLES =
    (TICK_PERIOD_MS * 1000000) / CLK_PERIOD_NS;
  localparam int PRESCALE_W = 24;
  localparam int TICK_COUNT_W = 4;
  localparam logic [PRESCALE_W-1:0] PRESCALE_RESET = 24'h00_0000;
  localparam logic [TICK_COUNT_W-1:0] TICK_COUNT_RESET = 4'h0;

  // Stretch length in ticks for rate code 0 (50 ms)
  localparam int STRETCH_MS_SHORTEST = 50;
  localparam int STRETCH_BASE_TICKS = STRETCH_MS_SHORTEST / TICK_PERIOD_MS;
  localparam int STRETCH_COUNT_W = 5;
  localparam logic [STRETCH_COUNT_W-1:0] STRETCH_COUNT_RESET = 5'h00;

  // Pin levels
  localparam logic [LAMP_COUNT-1:0] LAMP_OUT_RESET = 4'hF;

  typedef enum logic [1:0] {
    SPEED_10 = 2'b00,
    SPEED_100 = 2'b01,
    SPEED_1000 = 2'b10,
    SPEED_NONE = 2'b11
  } link_speed_e;

  typedef enum logic [3:0] {
    MODE_LINK_ACT = 4'b0000,
    MODE_LINK1000_ACT = 4'b0001,
    MODE_LINK100_ACT = 4'b0010,
    MODE_LINK10_ACT = 4'b0011,
    MODE_LINK100_1000_ACT = 4'b0100,
    MODE_LINK10_1000_ACT = 4'b0101,
    MODE_LINK10_100_ACT = 4'b0110,
    MODE_RSVD7 = 4'b0111,
    MODE_DUPLEX_COLL = 4'b1000,
    MODE_COLLISION = 4'b1001,
    MODE_ACTIVITY = 4'b1010,
    MODE_RSVD11 = 4'b1011,
    MODE_ANEG_FAULT = 4'b1100,
    MODE_RSVD13 = 4'b1101,
    MODE_FORCE_OFF = 4'b1110,
    MODE_FORCE_ON = 4'b1111
  } lamp_mode_e;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_ON = 2'b01,
    ST_OFF = 2'b10
  } stretch_phase_e;

  typedef struct packed {
    logic linkUp;
    link_speed_e speed;
    logic fullDuplex;
    logic rxActivity;
    logic txActivity;
    logic collision;
    logic anegFault;
  } link_status_s;

  typedef struct packed {
    lamp_mode_e mode;
    logic combineDisable;
    logic stretchEnable;
    logic [1:0] rate;
  } pin_cfg_s;

endpackage : lamp_pkg

// ---- core/lamp_timebase.sv ----
/*
 Shared time base: a 25 ms tick and a free-running tick count whose
 bits give the four blink phases.
 Assumes a single clock and an asynchronous active-high reset.
*/
`timescale 1ns/1ps
module lamp_timebase
  import lamp_pkg::*;
#(
  parameter int unsigned TICK_LEN = TICK_CYCLES
) (
  input wire logic ref_clk,
  input wire logic rst,
  output logic tick,
  output logic [TICK_COUNT_W-1:0] tickCount
);

  typedef struct packed {
    logic [PRESCALE_W-1:0] prescale;
    logic tick;
    logic [TICK_COUNT_W-1:0] count;
  } tb_state_s;

  tb_state_s state_reg;
  tb_state_s state_next;

  ////////////////////////////////////////////////////////////////////////
  always_comb begin
    state_next = state_reg;
    state_next.tick = 1'b0;
    if (state_reg.prescale == PRESCALE_W'(TICK_LEN - 1)) begin
      state_next.prescale = PRESCALE_RESET;
      state_next.tick = 1'b1;
      state_next.count = state_reg.count + 4'h1;
    end else begin
      state_next.prescale = state_reg.prescale + 24'h00_0001;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state_reg <= '{PRESCALE_RESET, 1'b0, TICK_COUNT_RESET};
    end else begin
      state_reg <= state_next;
    end
  end

  assign tick = state_reg.tick;
  assign tickCount = state_reg.count;

endmodule : lamp_timebase

// ---- core/lamp_stretcher.sv ----
/*
 One pulse stretcher: an event lights the lamp for a stretch period,
 then darkens it for the same period before the next event is taken.
 Assumes tick pulses one cycle in every 25 ms.
*/
`timescale 1ns/1ps
module lamp_stretcher
  import lamp_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic tick,
  input wire logic event_in,
  input wire logic [1:0] rate,
  output logic busy,
  output logic lit
);

  typedef struct packed {
    stretch_phase_e phase;
    logic [STRETCH_COUNT_W-1:0] count;
  } st_state_s;

  st_state_s state_reg;
  st_state_s state_next;
  logic [STRETCH_COUNT_W-1:0] loadValue;

  ////////////////////////////////////////////////////////////////////////
  // One extra tick so a partial first tick never shortens the period
  assign loadValue =
    STRETCH_COUNT_W'((STRETCH_BASE_TICKS << rate) + 1);

  always_comb begin
    state_next = state_reg;
    case (state_reg.phase)
      ST_IDLE: begin
        if (event_in) begin
          state_next.phase = ST_ON;
          state_next.count = loadValue;
        end
      end
      ST_ON: begin
        if (tick) begin
          state_next.count = state_reg.count - 5'h01;
          if (state_reg.count == 5'h01) begin
            state_next.phase = ST_OFF;
            state_next.count = loadValue;
          end
        end
      end
      ST_OFF: begin
        if (tick) begin
          state_next.count = state_reg.count - 5'h01;
          if (state_reg.count == 5'h01) begin
            state_next.phase = ST_IDLE;
            state_next.count = STRETCH_COUNT_RESET;
          end
        end
      end
      default: begin
        state_next.phase = ST_IDLE;
        state_next.count = STRETCH_COUNT_RESET;
      end
    endcase
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state_reg <= '{ST_IDLE, STRETCH_COUNT_RESET};
    end else begin
      state_reg <= state_next;
    end
  end

  assign busy = (state_reg.phase != ST_IDLE);
  assign lit = (state_reg.phase == ST_ON);

endmodule : lamp_stretcher

// ---- core/status_lamp_driver.sv ----
/*
 Four-pin status lamp driver: per-pin mode decode, combine, blink and
 pulse stretch, and output polarity.
 Assumes link status and settings are synchronous to ref_clk and that
 the lamps are wired to status_lamp_out.
*/
`timescale 1ns/1ps
module status_lamp_driver
  import lamp_pkg::*;
#(
  parameter int unsigned TICK_LEN = TICK_CYCLES
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire link_status_s linkStatus,
  input wire pin_cfg_s [LAMP_COUNT-1:0] pinCfg,
  input wire logic invertPolarity,
  input wire logic activityTxOnly,
  output logic [LAMP_COUNT-1:0] status_lamp_out
);

  typedef struct packed {
    logic [LAMP_COUNT-1:0] lampOut;
  } drv_state_s;

  drv_state_s state_reg;
  drv_state_s state_next;

  logic tick;
  logic [TICK_COUNT_W-1:0] tickCount;
  logic [LAMP_COUNT-1:0] primary;
  logic [LAMP_COUNT-1:0] secondary;
  logic [LAMP_COUNT-1:0] stretchBusy;
  logic [LAMP_COUNT-1:0] stretchLit;
  logic [LAMP_COUNT-1:0] asserted;
  logic link10;
  logic link100;
  logic link1000;
  logic anyActivity;
  logic modeActivity;

  ////////////////////////////////////////////////////////////////////////
  // Time base
  lamp_timebase #(
    .TICK_LEN(TICK_LEN)
  ) u_timebase (
    .ref_clk(ref_clk),
    .rst(rst),
    .tick(tick),
    .tickCount(tickCount)
  );

  ////////////////////////////////////////////////////////////////////////
  // Link qualification
  assign link10 = linkStatus.linkUp && (linkStatus.speed == SPEED_10);
  assign link100 = linkStatus.linkUp && (linkStatus.speed == SPEED_100);
  assign link1000 = linkStatus.linkUp && (linkStatus.speed == SPEED_1000);
  assign anyActivity = linkStatus.rxActivity || linkStatus.txActivity;
  assign modeActivity = activityTxOnly ? linkStatus.txActivity
                                       : anyActivity;

  ////////////////////////////////////////////////////////////////////////
  // Per-pin decode and stretchers
  for (genvar p = 0; p < LAMP_COUNT; p++) begin : g_pin
    logic linkQual;
    logic event_raw;
    logic overlayOn;

    // Primary indication and raw secondary event per mode
    always_comb begin
      linkQual = 1'b0;
      event_raw = 1'b0;
      overlayOn = 1'b1;
      primary[p] = 1'b0;
      case (pinCfg[p].mode)
        MODE_LINK_ACT: begin
          linkQual = link10 || link100 || link1000;
        end
        MODE_LINK1000_ACT: begin
          linkQual = link1000;
        end
        MODE_LINK100_ACT: begin
          linkQual = link100;
        end
        MODE_LINK10_ACT: begin
          linkQual = link10;
        end
        MODE_LINK100_1000_ACT: begin
          linkQual = link100 || link1000;
        end
        MODE_LINK10_1000_ACT: begin
          linkQual = link10 || link1000;
        end
        MODE_LINK10_100_ACT: begin
          linkQual = link10 || link100;
        end
        MODE_DUPLEX_COLL: begin
          primary[p] = linkStatus.linkUp && linkStatus.fullDuplex;
          event_raw = linkStatus.linkUp && !linkStatus.fullDuplex
                      && linkStatus.collision;
        end
        MODE_COLLISION: begin
          event_raw = linkStatus.collision;
        end
        MODE_ACTIVITY: begin
          event_raw = modeActivity;
        end
        MODE_ANEG_FAULT: begin
          primary[p] = linkStatus.anegFault;
          overlayOn = 1'b0;
        end
        MODE_FORCE_OFF: begin
          overlayOn = 1'b0;
        end
        MODE_FORCE_ON: begin
          primary[p] = 1'b1;
          overlayOn = 1'b0;
        end
        default: begin
          overlayOn = 1'b0;
        end
      endcase
      if (pinCfg[p].mode <= MODE_LINK10_100_ACT) begin
        primary[p] = linkQual;
        event_raw = linkQual && anyActivity;
      end
      // Collision and activity modes have no primary to fall back on
      if (pinCfg[p].combineDisable && (pinCfg[p].mode != MODE_COLLISION)
          && (pinCfg[p].mode != MODE_ACTIVITY)) begin
        overlayOn = 1'b0;
      end
      secondary[p] = overlayOn && event_raw;
    end

    lamp_stretcher u_stretch (
      .ref_clk(ref_clk),
      .rst(rst),
      .tick(tick),
      .event_in(secondary[p] && pinCfg[p].stretchEnable),
      .rate(pinCfg[p].rate),
      .busy(stretchBusy[p]),
      .lit(stretchLit[p])
    );

    // Rate code 0 uses the slowest count bit, code 3 the fastest
    always_comb begin
      // Stretch left over from an earlier mode never overrides the primary of a mode whose overlay is off
      if (pinCfg[p].stretchEnable) begin
        asserted[p] = (stretchBusy[p] && overlayOn) ? stretchLit[p]
                                                    : primary[p];
      end else if (secondary[p]) begin
        asserted[p] = tickCount[2'd3 - pinCfg[p].rate];
      end else begin
        asserted[p] = primary[p];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Output polarity and register
  always_comb begin
    state_next.lampOut = invertPolarity ? asserted : ~asserted;
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state_reg.lampOut <= LAMP_OUT_RESET;
    end else begin
      state_reg <= state_next;
    end
  end

  assign status_lamp_out = state_reg.lampOut;

endmodule : status_lamp_driver

// ---- verification/lamp_led_model.sv ----
/*
 External lamps on the four status pins: each one glows while its pin
 sits at the asserted level.
 Assumes the polarity setting that the driver itself is given.
*/
`timescale 1ns/1ps
module lamp_led_model
  import lamp_pkg::*;
(
  input wire logic [LAMP_COUNT-1:0] pinLevel,
  input wire logic invertPolarity,
  output logic [LAMP_COUNT-1:0] glow
);
  // Asserted level is low unless inverted
  assign glow = ~(pinLevel ^ {LAMP_COUNT{invertPolarity}});
endmodule : lamp_led_model

// ---- verification/status_lamp_driver_chk.sv ----
/*
 Port checker for the status lamp driver, bound to its top module.
 Assumes ref_clk and active-high rst at the driver's ports.
*/
`timescale 1ns/1ps
module status_lamp_driver_chk
  import lamp_pkg::*;
#(
  parameter int unsigned TICK_LEN = TICK_CYCLES
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire link_status_s linkStatus,
  input wire pin_cfg_s [LAMP_COUNT-1:0] pinCfg,
  input wire logic invertPolarity,
  input wire logic activityTxOnly,
  input wire logic [LAMP_COUNT-1:0] status_lamp_out
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  logic invHold;
  logic lit0;
  pin_cfg_s c0;
  assign c0 = pinCfg[0];
  assign lit0 = status_lamp_out[0] == invHold;
  always_ff @(posedge ref_clk) begin
    invHold <= invertPolarity;
  end
  ////////////////////////////////////////////////////////////////////////
  property p_reset;
    $fell(rst) |-> status_lamp_out == LAMP_OUT_RESET;
  endproperty
  a_reset: assert property (p_reset) else $error("lamps lit at reset");
  property p_force;
    c0.mode inside {MODE_FORCE_OFF, MODE_FORCE_ON}
      |=> lit0 == $past(c0.mode[0]);
  endproperty
  a_force: assert property (p_force) else $error("forced level wrong");
  property p_rsvd;
    c0.mode inside {MODE_RSVD7, MODE_RSVD11, MODE_RSVD13} |=> !lit0;
  endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved mode lit");
  property p_link;
    c0.mode == MODE_LINK_ACT && c0.combineDisable
      |=> lit0 == $past(linkStatus.linkUp);
  endproperty
  a_link: assert property (p_link) else $error("link lamp wrong");
  property p_gig;
    c0.mode == MODE_LINK1000_ACT && c0.combineDisable
      && linkStatus.speed != SPEED_1000 |=> !lit0;
  endproperty
  a_gig: assert property (p_gig) else $error("gigabit lamp lit");
  property p_duplex;
    c0.mode == MODE_DUPLEX_COLL && c0.combineDisable && linkStatus.linkUp
      && linkStatus.fullDuplex |=> lit0;
  endproperty
  a_duplex: assert property (p_duplex) else $error("duplex dark");
  property p_aneg;
    c0.mode == MODE_ANEG_FAULT |=> lit0 == $past(linkStatus.anegFault);
  endproperty
  a_aneg: assert property (p_aneg) else $error("fault lamp dark");
  property p_txonly;
    c0.mode == MODE_ACTIVITY && activityTxOnly && !c0.stretchEnable
      && !linkStatus.txActivity |=> !lit0;
  endproperty
  a_txonly: assert property (p_txonly) else $error("rx shown");
  c_blink: cover property (c0.mode == MODE_LINK_ACT && c0.rate == 2'h3);
  c_stretch: cover property (c0.stretchEnable && $fell(lit0));
  c_invert: cover property (invertPolarity && lit0);
endmodule : status_lamp_driver_chk

bind status_lamp_driver status_lamp_driver_chk #(.TICK_LEN(TICK_LEN)) chk_u (
  .ref_clk(ref_clk), .rst(rst), .linkStatus(linkStatus), .pinCfg(pinCfg),
  .invertPolarity(invertPolarity), .activityTxOnly(activityTxOnly),
  .status_lamp_out(status_lamp_out));

// ---- verification/tb_status_lamp_driver.sv ----
/*
 Bench for the status lamp driver: mode tables, blink and stretch timing.
 Assumes lamp_pkg, the driver, the lamp model and the checker compiled.
*/
`timescale 1ns/1ps
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin fail_count++; \
  $display("BAD %0t got %h exp %h", $time, g, e); end end
module tb_status_lamp_driver;
  import lamp_pkg::*;
  localparam int TL = 10;
  logic ref_clk, rst, invertPolarity, activityTxOnly;
  link_status_s linkStatus;
  pin_cfg_s [LAMP_COUNT-1:0] pinCfg;
  logic [LAMP_COUNT-1:0] status_lamp_out, glow, expv;
  logic [8:0] pat;
  int fail_count, n_tests, cyc, n, on, off, lo;
  status_lamp_driver #(.TICK_LEN(TL)) dut_u (.ref_clk(ref_clk), .rst(rst),
    .linkStatus(linkStatus), .pinCfg(pinCfg),
    .invertPolarity(invertPolarity), .activityTxOnly(activityTxOnly),
    .status_lamp_out(status_lamp_out));
  lamp_led_model lamps_u (.pinLevel(status_lamp_out),
    .invertPolarity(invertPolarity), .glow(glow));
  ////////////////////////////////////////////////////////////////////////
  function automatic logic qual(input int m, input int s);
    case (m)
      0: return s != 3;
      1: return s == 2;
      2: return s == 1;
      3: return s == 0;
      4: return s == 1 || s == 2;
      5: return s == 0 || s == 2;
      default: return s == 0 || s == 1;
    endcase
  endfunction : qual
  task automatic cfg_all(input int m, input logic cd, input logic se,
      input logic [1:0] r);
    for (int k = 0; k < LAMP_COUNT; k++)
      pinCfg[k] <= '{lamp_mode_e'(m), cd, se, r};
  endtask : cfg_all
  task automatic wait_flip(output int c);
    logic g0;
    g0 = glow[0];
    c = 0;
    do begin
      @(posedge ref_clk);
      #1 c++;
    end while (glow[0] === g0 && c < 1000);
  endtask : wait_flip
  task automatic wrap_up;
    $display("Checks %0d, mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : wrap_up
  ////////////////////////////////////////////////////////////////////////
  initial begin
    ref_clk = 1'h0;
    forever #20 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 20000) begin
      fail_count++;
      wrap_up();
    end
  end
  initial begin
    rst = 1'h1;
    invertPolarity = 1'h0;
    activityTxOnly = 1'h1;
    linkStatus = '0;
    pinCfg = '0;
    repeat (20) @(posedge ref_clk);
    rst <= 1'h0;
    // Speed-qualified link modes, one mode apart across the four pins, both polarities
    for (int v = 0; v < 2; v++)
      for (int m = 0; m < 7; m++)
        for (int s = 0; s < 4; s++) begin
          @(posedge ref_clk);
          invertPolarity <= v[0];
          linkStatus <= '{s != 3, link_speed_e'(s), 1'h1, 1'h1, 1'h0,
            1'h0, 1'h0};
          for (int k = 0; k < LAMP_COUNT; k++) begin
            pinCfg[k] <= '{lamp_mode_e'((m + k) % 7), 1'h1, 1'h0, 2'h0};
            expv[k] = qual((m + k) % 7, s);
          end
          repeat (3) @(posedge ref_clk);
          #1 `CHK(glow, expv)
        end
    // Duplex, collision, tx-only, fault, reserved and forced modes
    for (int a = 0; a < 2; a++)
      for (int m = 7; m < 16; m++) begin
        @(posedge ref_clk);
        invertPolarity <= 1'h0;
        linkStatus <= '{1'h1, SPEED_1000, a[0], 1'h1, 1'h0, 1'h0, a[0]};
        cfg_all(m, 1'h1, 1'h0, 2'h0);
        pat = a ? 9'h122 : 9'h100;
        repeat (3) @(posedge ref_clk);
        #1 `CHK(glow, {4{pat[m-7]}})
      end
    // Blink half periods per rate code
    for (int r = 0; r < 4; r++) begin
      @(posedge ref_clk);
      linkStatus <= '{1'h1, SPEED_100, 1'h1, 1'h1, 1'h0, 1'h0, 1'h0};
      cfg_all(0, 1'h0, 1'h0, r[1:0]);
      // First flip may be the rate change itself, not a blink edge
      wait_flip(n);
      wait_flip(n);
      wait_flip(on);
      wait_flip(off);
      `CHK(on, (8 >> r) * TL)
      `CHK(off, (8 >> r) * TL)
    end
    // Stretch of a one-cycle collision, events held while stretched
    for (int r = 0; r < 4; r++) begin
      @(posedge ref_clk);
      linkStatus <= '0;
      cfg_all(9, 1'h0, 1'h1, r[1:0]);
      repeat (400) @(posedge ref_clk);
      linkStatus.collision <= 1'h1;
      @(posedge ref_clk);
      linkStatus.collision <= 1'h0;
      wait_flip(n);
      @(posedge ref_clk);
      linkStatus.collision <= 1'h1;
      wait_flip(on);
      wait_flip(off);
      on++;
      lo = (2 << r) * TL;
      `CHK(on >= lo && on <= lo + TL + 3 && off >= lo, 1'h1)
      `CHK(off <= lo + TL + 3, 1'h1)
    end
    // Stretched rx activity in mode 10, half-duplex collision in mode 8
    for (int j = 0; j < 2; j++) begin
      @(posedge ref_clk);
      linkStatus <= '0;
      activityTxOnly <= 1'h0;
      cfg_all(j ? 8 : 10, 1'h0, 1'h1, 2'h0);
      repeat (400) @(posedge ref_clk);
      linkStatus <= '{1'h1, SPEED_10, 1'h0, !j[0], 1'h0, j[0], 1'h0};
      repeat (3) @(posedge ref_clk);
      #1 `CHK(glow, 4'hF)
    end
    wrap_up();
  end
endmodule : tb_status_lamp_driver
